// ==== design/sfcp_pkg.sv ====
// Shared constants and types for the serial flash command and protection front end.
// Assumes a 25 MHz system clock; the serial bus clock comes from the bus host.
package sfcp_pkg;

	// ------------------------------------------------------------
	// Opcodes
	// ------------------------------------------------------------
	localparam logic [7:0] CMD_WRITE_ENABLE      = 8'h06;
	localparam logic [7:0] CMD_WRITE_DISABLE     = 8'h04;
	localparam logic [7:0] CMD_IDENT_READ        = 8'h9F;
	localparam logic [7:0] CMD_STATUS_READ       = 8'h05;
	localparam logic [7:0] CMD_STATUS_WRITE      = 8'h01;
	localparam logic [7:0] CMD_READ              = 8'h03;
	localparam logic [7:0] CMD_FAST_READ         = 8'h0B;
	localparam logic [7:0] CMD_SECTOR_ERASE      = 8'h20;
	localparam logic [7:0] CMD_BLOCK_ERASE       = 8'hD8;
	localparam logic [7:0] CMD_CHIP_ERASE_A      = 8'h60;
	localparam logic [7:0] CMD_CHIP_ERASE_B      = 8'hC7;
	localparam logic [7:0] CMD_PAGE_PROGRAM      = 8'h02;
	localparam logic [7:0] CMD_SLEEP             = 8'hB9;
	localparam logic [7:0] CMD_WAKE              = 8'hAB;
	localparam logic [7:0] CMD_MAKER_DEVICE_READ = 8'h90;

	// ------------------------------------------------------------
	// Array organisation and status layout
	// ------------------------------------------------------------
	localparam int ADDR_W       = 18;
	localparam int PAGE_BYTES   = 256;
	localparam int SECTOR_BYTES = 4096;
	localparam int BLOCK_BYTES  = 65536;
	localparam int BLK_MSB      = 17;
	localparam int BLK_LSB      = 16;
	localparam int ST_BUSY_BIT  = 0;
	localparam int ST_LATCH_BIT = 1;
	localparam int ST_GLO_BIT   = 2;
	localparam int ST_GHI_BIT   = 3;
	localparam int ST_LOCK_BIT  = 7;
	localparam logic [1:0] GUARD_RST = 2'h0;
	localparam logic       LOCK_RST  = 1'h0;
	localparam logic [7:0] ERASED_BYTE = 8'hFF;

	// ------------------------------------------------------------
	// Frame lengths in bits and first answer byte of each read
	// ------------------------------------------------------------
	localparam logic [15:0] LEN_OPCODE   = 16'h0008;
	localparam logic [15:0] LEN_CMD_STATUS_WRITE     = 16'h0010;
	localparam logic [15:0] LEN_ADDR     = 16'h0020;
	localparam logic [15:0] LEN_PROG_MIN = 16'h0028;
	localparam logic [15:0] WDATA_LAST   = 16'h000F;
	localparam logic [12:0] RSP_IDENT    = 13'h0001;
	localparam logic [12:0] RSP_READ     = 13'h0004;
	localparam logic [12:0] RSP_FAST     = 13'h0005;

	// ------------------------------------------------------------
	// Timing
	// ------------------------------------------------------------
	localparam int CLK_SYS_NS      = 40;
	localparam int PROG_TIME_NS    = 1_400_000;
	localparam int SECTOR_TIME_NS  = 60_000_000;
	localparam int BLOCK_TIME_NS   = 1_000_000_000;
	localparam int STATUS_TIME_NS  = 15_000_000;
	localparam int POWERUP_TIME_NS = 1_000_000;
	localparam int PROG_CYC   = (PROG_TIME_NS + CLK_SYS_NS - 1) / CLK_SYS_NS;
	localparam int SECTOR_CYC = (SECTOR_TIME_NS + CLK_SYS_NS - 1) / CLK_SYS_NS;
	localparam int BLOCK_CYC  = (BLOCK_TIME_NS + CLK_SYS_NS - 1) / CLK_SYS_NS;
	localparam int CHIP_CYC   = 4 * BLOCK_CYC;
	localparam int STATUS_CYC = (STATUS_TIME_NS + CLK_SYS_NS - 1) / CLK_SYS_NS;
	localparam int PUW_CYC    = (POWERUP_TIME_NS + CLK_SYS_NS - 1) / CLK_SYS_NS;

	// ------------------------------------------------------------
	// Types
	// ------------------------------------------------------------
	typedef enum logic [2:0] {OP_NONE, OP_PROG, OP_SECT, OP_BLOCK, OP_CHIP, OP_STAT} sfcp_op_t;
	typedef enum logic {ST_READY, ST_BUSY} sfcp_state_t;

endpackage

// ==== design/sfcp_sync.sv ====
// Two-stage level synchroniser, a bit vector of quasi-static or single-bit levels.
// Assumes each bit changes rarely compared with the destination clock.
`timescale 1ns/100ps
module sfcp_sync #(
	parameter int         W       = 1,
	parameter logic [W-1:0] RST_VAL = '0
) (
	input  wire logic         clk,
	input  wire logic         reset_n,
	input  wire logic [W-1:0] din,
	output logic      [W-1:0] dout
);
	logic [W-1:0] meta_r;

	// First stage feeds only the second stage
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			meta_r <= RST_VAL;
			dout   <= RST_VAL;
		end else begin
			meta_r <= din;
			dout   <= meta_r;
		end
	end
endmodule // sfcp_sync

// ==== design/sfcp_flash.sv ====
// Command decoder, write latch and protection for a small serial NOR flash.
// Assumes a bus host on link_clk/cs_n/si/hold_n and an array engine fed by op_start_r.
//
// How it works
// - Idle clock high or low both work; first falling edge before data is harmless.
// - Addresses use the low 18 bits of the three address bytes.
// - Page program starts one self-timed page operation; host supplies no timing.
// - Erase opcodes pick a sector, a block or the whole chip.
// - Busy flag set during program, erase or status write, cleared at completion.
// - Select high with nothing running raises the standby output.
// - Reset puts the command machine in the ready (read) state.
// - Commands whose bit count is not a whole byte are dropped, except wake (AB) while asleep.
// - Program, erase and status write need the write latch set first.
// - Latch clears at reset, write-disable and end of every write operation.
// - Guard level bits protect none, top block, top two blocks or all.
// - Protect pin low with lock set freezes guard and lock bits.
// - In sleep only the wake and signature opcode is honoured.
// - Pause freezes the serial side but running operations continue.
// - Pause starts with select low, at a clock-low moment.
// - Pause ends when the pause pin is high at a clock-low moment.
// - Paused: output released, input and clock edges ignored.
// - Select high during pause resets the serial side.
// - Single byte opcodes 06, 04, 9F, 05, 01 decode as listed.
// - Read 03 plus address, fast read 0B plus address and dummy, stream till select.
// - Sector erase 20, block erase D8, chip erase 60 or C7, program 02.
// - B9 enters sleep; AB wakes and, after three dummies, gives the signature.
// - 90 with two dummies then address byte; its bit 0 picks the first id.
// - Bits are sampled on rising clock and shifted out on falling clock.
// - Write type commands must end exactly on a byte boundary or are rejected.
// - Hard guard is lock set and protect low; status writes then refused.
`timescale 1ns/100ps
module sfcp_flash
	import sfcp_pkg::*;
#(
	parameter int unsigned    PROG_CYCLES   = sfcp_pkg::PROG_CYC,
	parameter int unsigned    SECT_CYCLES   = sfcp_pkg::SECTOR_CYC,
	parameter int unsigned    BLOCK_CYCLES  = sfcp_pkg::BLOCK_CYC,
	parameter int unsigned    CHIP_CYCLES   = sfcp_pkg::CHIP_CYC,
	parameter int unsigned    STAT_CYCLES   = sfcp_pkg::STATUS_CYC,
	parameter int unsigned    PUW_CYCLES    = sfcp_pkg::PUW_CYC,
	parameter logic     [7:0] MAKER_ID      = 8'h5A, // Arbitrary value
	parameter logic     [7:0] TYPE_ID       = 8'h3C, // Arbitrary value
	parameter logic     [7:0] DEVICE_ID     = 8'h11  // Arbitrary value
) (
	input  wire logic                   clk_sys,
	input  wire logic                   reset_n,
	input  wire logic                   link_clk,
	input  wire logic                   cs_n,
	input  wire logic                   si,
	input  wire logic                   hold_n,
	input  wire logic                   protect_n,
	output logic                        so_r,
	output logic                        so_oe_n_r,
	output logic                        busy_flag_r,
	output logic                        write_latch_r,
	output logic [1:0]                  guard_level_r,
	output logic                        status_lock_r,
	output logic                        sleep_r,
	output logic                        standby_r,
	output logic                        reject_r,
	output logic                        op_start_r,
	output sfcp_pkg::sfcp_op_t          op_kind_r,
	output logic [sfcp_pkg::ADDR_W-1:0] op_addr_r
);
	import sfcp_pkg::*;

	// ------------------------------------------------------------
	// Helpers
	// ------------------------------------------------------------
	// True when the block holding an address lies in the guarded region
	function automatic logic is_guarded(input logic [1:0] level, input logic [1:0] blk);
		case (level)
			2'h0:    is_guarded = 1'b0;
			2'h1:    is_guarded = (blk == 2'h3);
			2'h2:    is_guarded = blk[1];
			default: is_guarded = 1'b1;
		endcase
	endfunction

	// ------------------------------------------------------------
	// Link side: serial shift-in on the bus clock
	// ------------------------------------------------------------
	logic        link_rst;
	logic        fresh_r;
	logic        start_tgl_r;
	logic [15:0] bit_cnt_r;
	logic [15:0] cnt_eff;
	logic [7:0]  shift_r;
	logic [7:0]  opcode_r;
	logic [23:0] addr_r;
	logic [7:0]  wdata_r;
	logic [8:0]  stat_link;
	logic        tx_en;
	logic [7:0]  tx_byte;
	logic [12:0] byte_idx;

	// Select high ends the frame and resets the serial side, paused or not
	assign link_rst = cs_n | ~reset_n;
	assign cnt_eff  = fresh_r ? 16'h0000 : bit_cnt_r;
	assign byte_idx = cnt_eff[15:3];

	// Marks a new frame; cleared by its first accepted rising edge
	always_ff @(posedge link_clk or posedge link_rst) begin
		if (link_rst) begin
			fresh_r <= 1'b1;
		end else if (hold_n) begin
			fresh_r <= 1'b0;
		end
	end

	// Sample on rising edge; a paused edge is ignored
	always_ff @(posedge link_clk or negedge reset_n) begin
		if (!reset_n) begin
			bit_cnt_r   <= 16'h0000;
			shift_r     <= 8'h00;
			opcode_r    <= 8'h00;
			addr_r      <= 24'h000000;
			wdata_r     <= 8'h00;
			start_tgl_r <= 1'b0;
		end else if (hold_n && !cs_n) begin
			bit_cnt_r <= cnt_eff + 16'h0001;
			shift_r   <= {shift_r[6:0], si};
			if (fresh_r) begin
				start_tgl_r <= ~start_tgl_r;
			end
			if (cnt_eff == LEN_OPCODE - 16'h0001) begin
				opcode_r <= {shift_r[6:0], si};
			end
			if (cnt_eff >= LEN_OPCODE && cnt_eff < LEN_ADDR) begin
				addr_r <= {addr_r[22:0], si};
			end
			if (cnt_eff >= LEN_OPCODE && cnt_eff <= WDATA_LAST) begin
				wdata_r <= {wdata_r[6:0], si};
			end
		end
	end

	// Status and sleep seen from the bus clock
	sfcp_sync #(.W(9), .RST_VAL(9'h000)) u_stat_sync (
		.clk     (link_clk),
		.reset_n (reset_n),
		.din     ({sleep_r, status_lock_r, 3'h0, guard_level_r, write_latch_r, busy_flag_r}),
		.dout    (stat_link)
	);

	// Answer byte for the current byte slot
	always_comb begin
		tx_en   = 1'b0;
		tx_byte = ERASED_BYTE;
		if (cnt_eff >= LEN_OPCODE) begin
			if (stat_link[8]) begin
				if (opcode_r == CMD_WAKE && byte_idx >= RSP_READ) begin
					tx_en   = 1'b1;
					tx_byte = DEVICE_ID;
				end
			end else if (opcode_r == CMD_STATUS_READ) begin
				tx_en   = 1'b1;
				tx_byte = stat_link[7:0];
			end else if (!stat_link[ST_BUSY_BIT]) begin
				case (opcode_r)
					CMD_IDENT_READ: begin
						tx_en = 1'b1;
						if (byte_idx == RSP_IDENT) begin
							tx_byte = MAKER_ID;
						end else if (byte_idx == RSP_IDENT + 13'h0001) begin
							tx_byte = TYPE_ID;
						end else if (byte_idx == RSP_IDENT + 13'h0002) begin
							tx_byte = DEVICE_ID;
						end
					end
					CMD_READ: begin
						tx_en = (byte_idx >= RSP_READ);
					end
					CMD_FAST_READ: begin
						tx_en = (byte_idx >= RSP_FAST);
					end
					CMD_WAKE: begin
						tx_en   = (byte_idx >= RSP_READ);
						tx_byte = DEVICE_ID;
					end
					CMD_MAKER_DEVICE_READ: begin
						tx_en   = (byte_idx >= RSP_READ);
						tx_byte = (byte_idx[0] ^ addr_r[0]) ? DEVICE_ID : MAKER_ID;
					end
					default: begin
						tx_en = 1'b0;
					end
				endcase
			end
		end
	end

	// Shift out on falling edge; released while paused or idle
	always_ff @(negedge link_clk or posedge link_rst) begin
		if (link_rst) begin
			so_r      <= 1'b0;
			so_oe_n_r <= 1'b1;
		end else if (!hold_n) begin
			so_oe_n_r <= 1'b1;
		end else if (tx_en) begin
			so_oe_n_r <= 1'b0;
			so_r      <= tx_byte[3'h7 - cnt_eff[2:0]];
		end else begin
			so_oe_n_r <= 1'b1;
		end
	end

	AST_PAUSE_HIZ: assert property (@(negedge link_clk) disable iff (link_rst)
		!hold_n |=> so_oe_n_r)
		else $error("output driven while paused");

	// ------------------------------------------------------------
	// System side: frame decode
	// ------------------------------------------------------------
	logic        cs_s;
	logic        prot_s;
	logic        tgl_s;
	logic        cs_d_r;
	logic        seen_tgl_r;
	logic        frame_end;
	logic        hard_guard;
	logic        puw_done;
	logic [31:0] puw_cnt_r;
	logic [1:0]  blk;
	sfcp_state_t state_r;
	logic [31:0] timer_r;
	logic [7:0]  pend_r;
	sfcp_op_t    start_kind;
	logic [31:0] start_len;

	// Resets to idle levels: deselected, unprotected, toggle clear, so no false frame end
	sfcp_sync #(.W(3), .RST_VAL(3'h6)) u_pin_sync (
		.clk     (clk_sys),
		.reset_n (reset_n),
		.din     ({cs_n, protect_n, start_tgl_r}),
		.dout    ({cs_s, prot_s, tgl_s})
	);

	// Frame fields are static once select is high, so they are read directly
	assign frame_end  = cs_s && !cs_d_r && (tgl_s != seen_tgl_r);
	assign hard_guard = status_lock_r && !prot_s;
	assign puw_done   = (puw_cnt_r >= PUW_CYCLES);
	assign blk        = addr_r[BLK_MSB:BLK_LSB];

	// Frame edge tracking
	always_ff @(posedge clk_sys or negedge reset_n) begin
		if (!reset_n) begin
			cs_d_r     <= 1'b1;
			seen_tgl_r <= 1'b0;
		end else begin
			cs_d_r <= cs_s;
			if (cs_s && !cs_d_r) begin
				seen_tgl_r <= tgl_s;
			end
		end
	end

	// Write delay after power-up
	always_ff @(posedge clk_sys or negedge reset_n) begin
		if (!reset_n) begin
			puw_cnt_r <= 32'h00000000;
		end else if (!puw_done) begin
			puw_cnt_r <= puw_cnt_r + 32'h00000001;
		end
	end

	// Which write operation a finished frame asks for
	always_comb begin
		start_kind = OP_NONE;
		start_len  = 32'h00000000;
		if (frame_end && state_r == ST_READY && !sleep_r && write_latch_r && puw_done) begin
			case (opcode_r)
				CMD_PAGE_PROGRAM: begin
					if (bit_cnt_r[2:0] == 3'h0 && bit_cnt_r >= LEN_PROG_MIN
						&& !is_guarded(guard_level_r, blk)) begin
						start_kind = OP_PROG;
						start_len  = PROG_CYCLES;
					end
				end
				CMD_SECTOR_ERASE: begin
					if (bit_cnt_r == LEN_ADDR && !is_guarded(guard_level_r, blk)) begin
						start_kind = OP_SECT;
						start_len  = SECT_CYCLES;
					end
				end
				CMD_BLOCK_ERASE: begin
					if (bit_cnt_r == LEN_ADDR && !is_guarded(guard_level_r, blk)) begin
						start_kind = OP_BLOCK;
						start_len  = BLOCK_CYCLES;
					end
				end
				CMD_CHIP_ERASE_A, CMD_CHIP_ERASE_B: begin
					if (bit_cnt_r == LEN_OPCODE && guard_level_r == 2'h0) begin
						start_kind = OP_CHIP;
						start_len  = CHIP_CYCLES;
					end
				end
				CMD_STATUS_WRITE: begin
					if (bit_cnt_r == LEN_CMD_STATUS_WRITE && !hard_guard) begin
						start_kind = OP_STAT;
						start_len  = STAT_CYCLES;
					end
				end
				default: begin
					start_kind = OP_NONE;
				end
			endcase
		end
	end

	// Busy machine; runs on even while the serial side is paused
	always_ff @(posedge clk_sys or negedge reset_n) begin
		if (!reset_n) begin
			state_r   <= ST_READY;
			timer_r   <= 32'h00000000;
			pend_r    <= 8'h00;
			op_kind_r <= OP_NONE;
			op_addr_r <= '0;
		end else begin
			case (state_r)
				ST_READY: begin
					if (start_kind != OP_NONE) begin
						state_r   <= ST_BUSY;
						timer_r   <= start_len;
						pend_r    <= wdata_r;
						op_kind_r <= start_kind;
						op_addr_r <= addr_r[ADDR_W-1:0];
					end
				end
				ST_BUSY: begin
					if (timer_r <= 32'h00000001) begin
						state_r <= ST_READY;
					end else begin
						timer_r <= timer_r - 32'h00000001;
					end
				end
				default: begin
					state_r <= ST_READY;
				end
			endcase
		end
	end

	// Start pulse, refusal pulse, busy and standby
	always_ff @(posedge clk_sys or negedge reset_n) begin
		if (!reset_n) begin
			op_start_r  <= 1'b0;
			reject_r    <= 1'b0;
			busy_flag_r <= 1'b0;
			standby_r   <= 1'b0;
		end else begin
			op_start_r  <= (start_kind != OP_NONE);
			reject_r    <= frame_end && (start_kind == OP_NONE)
				&& (bit_cnt_r[2:0] != 3'h0 || write_latch_r == 1'b0 || sleep_r);
			busy_flag_r <= (state_r == ST_BUSY) || (start_kind != OP_NONE);
			standby_r   <= cs_s && (state_r == ST_READY) && (start_kind == OP_NONE);
		end
	end

	// Write latch, guard bits, lock and sleep
	always_ff @(posedge clk_sys or negedge reset_n) begin
		if (!reset_n) begin
			write_latch_r <= 1'b0;
			guard_level_r <= GUARD_RST;
			status_lock_r <= LOCK_RST;
			sleep_r       <= 1'b0;
		end else if (state_r == ST_BUSY && timer_r <= 32'h00000001) begin
			write_latch_r <= 1'b0;
			if (op_kind_r == OP_STAT) begin
				guard_level_r <= {pend_r[ST_GHI_BIT], pend_r[ST_GLO_BIT]};
				status_lock_r <= pend_r[ST_LOCK_BIT];
			end
		end else if (frame_end && state_r == ST_READY) begin
			if (sleep_r) begin
				if (opcode_r == CMD_WAKE) begin
					sleep_r <= 1'b0;
				end
			end else if (opcode_r == CMD_WRITE_ENABLE && bit_cnt_r == LEN_OPCODE) begin
				write_latch_r <= 1'b1;
			end else if (opcode_r == CMD_WRITE_DISABLE && bit_cnt_r == LEN_OPCODE) begin
				write_latch_r <= 1'b0;
			end else if (opcode_r == CMD_SLEEP && bit_cnt_r == LEN_OPCODE) begin
				sleep_r <= 1'b1;
			end
		end
	end

	// ------------------------------------------------------------
	// Checks
	// ------------------------------------------------------------
	sequence s_started;
		op_start_r ##1 busy_flag_r;
	endsequence

	AST_LATCH_CLEARS: assert property (@(posedge clk_sys) disable iff (!reset_n)
		$fell(busy_flag_r) |-> !write_latch_r)
		else $error("write latch still set after operation end");

	AST_NEEDS_LATCH: assert property (@(posedge clk_sys) disable iff (!reset_n)
		op_start_r |-> $past(write_latch_r))
		else $error("write started without the latch");

	AST_GUARD: assert property (@(posedge clk_sys) disable iff (!reset_n)
		op_start_r && op_kind_r != OP_STAT |-> !is_guarded(guard_level_r, op_addr_r[BLK_MSB:BLK_LSB])
		&& (op_kind_r != OP_CHIP || guard_level_r == 2'h0))
		else $error("write started in a guarded block");

	AST_HARD_GUARD: assert property (@(posedge clk_sys) disable iff (!reset_n)
		op_start_r && op_kind_r == OP_STAT |-> !$past(hard_guard))
		else $error("status write accepted under hard guard");

	AST_SLEEP_QUIET: assert property (@(posedge clk_sys) disable iff (!reset_n)
		$past(sleep_r) |-> !op_start_r)
		else $error("write started while asleep");

	AST_STANDBY: assert property (@(posedge clk_sys) disable iff (!reset_n)
		cs_s && state_r == ST_READY && start_kind == OP_NONE |=> standby_r)
		else $error("standby not shown while idle");

	AST_BUSY_HOLDS: assert property (@(posedge clk_sys) disable iff (!reset_n)
		s_started |-> busy_flag_r[*2] ##0 (state_r == ST_BUSY))
		else $error("busy flag dropped right after start");

	AST_ALIGNED: assert property (@(posedge clk_sys) disable iff (!reset_n)
		op_start_r |-> $past(bit_cnt_r[2:0]) == 3'h0)
		else $error("write started from a partial byte");

endmodule // sfcp_flash

// ==== bench/sfcp_host.sv ====
// Serial bus host model: clock mode 0 frames at 6 ns, clock still between frames.
// Assumes the device samples si on rising link_clk and shifts so on falling link_clk.
`timescale 1ns/100ps
module sfcp_host (
	output logic      link_clk,
	output logic      cs_n,
	output logic      si,
	output logic      hold_n,
	input  wire logic so_r,
	input  wire logic so_oe_n_r
);
	logic oe_seen;
	logic paused_drive;
	int   pause_at;

	// Idle bus: select high, clock low, no pause
	initial begin
		link_clk = 1'b0;
		cs_n = 1'b1;
		si = 1'b0;
		hold_n = 1'b1;
		pause_at = -1;
		paused_drive = 1'b0;
	end

	// Shift n bits MSB first, gather so at each rising edge
	task automatic frame(input logic [63:0] tx, input int n, output logic [63:0] rx);
		rx = '0;
		oe_seen = 1'b0;
		cs_n = 1'b0;
		for (int i = n - 1; i >= 0; i--) begin
			// Optional pause with clock low; its edges and input must be ignored
			if (i == pause_at) begin
				hold_n = 1'b0;
				repeat (2) begin
					si = ~si;
					#3 link_clk = 1'b1;
					#3 link_clk = 1'b0;
					#1 paused_drive = paused_drive | !so_oe_n_r;
				end
				hold_n = 1'b1;
			end
			si = tx[i];
			#3 link_clk = 1'b1;
			rx = {rx[62:0], so_r};
			oe_seen = oe_seen | !so_oe_n_r;
			#3 link_clk = 1'b0;
		end
		#3 cs_n = 1'b1;
		si = ~si; // Undriven line shows no stale value
		#300;
	endtask
endmodule // sfcp_host

// ==== bench/serial_flash_cmd_protect_tb.sv ====
// Self-checking bench for the serial flash command and protection front end.
// Assumes sfcp_host drives the serial side; operation counts shortened to 20, power-up delay kept.
`timescale 1ns/100ps
module serial_flash_cmd_protect_tb;
	import sfcp_pkg::*;
	logic              clk_sys, reset_n, protect_n, link_clk, cs_n, si, hold_n;
	logic              so_r, so_oe_n_r, busy_flag_r, write_latch_r, status_lock_r;
	logic              sleep_r, standby_r, reject_r, op_start_r;
	logic [1:0]        guard_level_r;
	sfcp_op_t          op_kind_r;
	logic [ADDR_W-1:0] op_addr_r;
	logic [63:0]       rx;
	logic [15:0]       rnd;
	int                errors, checks_done, starts, rejects, mark;
	logic [7:0]        codes [5] = '{8'h20, 8'hD8, 8'h60, 8'hC7, 8'h02};
	sfcp_op_t          kinds [5] = '{OP_SECT, OP_BLOCK, OP_CHIP, OP_CHIP, OP_PROG};
	int                bits [5] = '{32, 32, 8, 8, 40};

	sfcp_flash #(.PROG_CYCLES(20), .SECT_CYCLES(20), .BLOCK_CYCLES(20),
		.CHIP_CYCLES(20), .STAT_CYCLES(20)) dut (
		.clk_sys(clk_sys), .reset_n(reset_n), .link_clk(link_clk), .cs_n(cs_n),
		.si(si), .hold_n(hold_n), .protect_n(protect_n), .so_r(so_r),
		.so_oe_n_r(so_oe_n_r), .busy_flag_r(busy_flag_r), .write_latch_r(write_latch_r),
		.guard_level_r(guard_level_r), .status_lock_r(status_lock_r), .sleep_r(sleep_r),
		.standby_r(standby_r), .reject_r(reject_r), .op_start_r(op_start_r),
		.op_kind_r(op_kind_r), .op_addr_r(op_addr_r));

	sfcp_host host (.link_clk(link_clk), .cs_n(cs_n), .si(si), .hold_n(hold_n),
		.so_r(so_r), .so_oe_n_r(so_oe_n_r));

	// System clock, 40 ns
	initial begin
		clk_sys = 1'b0;
		forever #20 clk_sys = ~clk_sys;
	end

	// Count started and rejected operations
	always @(posedge clk_sys) begin
		if (op_start_r === 1'b1) starts <= starts + 1;
		if (reject_r === 1'b1) rejects <= rejects + 1;
	end

	function automatic logic [15:0] lfsr(input logic [15:0] x);
		return {x[14:0], x[15] ^ x[13] ^ x[12] ^ x[10]};
	endfunction

	task automatic chk(input logic [63:0] seen, input logic [63:0] exp);
		checks_done++;
		if (seen !== exp) begin
			errors++;
			$display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask

	task automatic wr(input logic [63:0] tx, input int n);
		host.frame(tx, n, rx);
	endtask

	// Optional write enable, one command, then start count and latch
	task automatic do_op(input logic [63:0] tx, input int n, input logic en, input logic go);
		int s;
		s = starts;
		if (en) wr(64'h06, 8);
		wr(tx, n);
		repeat (10) @(posedge clk_sys);
		chk(starts - s, go);
		chk(busy_flag_r, go);
		for (int k = 0; k < 200 && busy_flag_r !== 1'b0; k++) @(posedge clk_sys);
		chk(busy_flag_r, 1'b0);
		chk(write_latch_r, en && !go);
		wr(64'h04, 8);
	endtask

	task automatic give_verdict();
		$display("errors=%0d checks_done=%0d", errors, checks_done);
		if (errors == 0 && checks_done > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask

	// Watchdog against a hung handshake
	initial begin
		#3_000_000;
		errors++;
		give_verdict();
	end

	// Main sequence
	initial begin
		reset_n = 1'b0;
		protect_n = 1'b1;
		errors = 0;
		checks_done = 0;
		starts = 0;
		rejects = 0;
		rnd = 16'hEBA8;
		repeat (2) @(posedge clk_sys);
		reset_n <= 1'b1;
		@(posedge clk_sys);
		chk({busy_flag_r, write_latch_r, guard_level_r, so_oe_n_r}, 5'h01);
		repeat (30) @(posedge clk_sys);
		wr(64'h0500, 16);
		chk(rx[7:0], 8'h00);
		wr(64'h06, 8);
		wr(64'h0500, 16);
		chk(rx[7:0], 8'h02);
		wr(64'h04, 8);
		wr(64'h0500, 16);
		chk(rx[7:0], 8'h00);
		chk(standby_r, 1'b1);
		// Writes are refused until the power-up delay has run out
		do_op(64'h20000000, 32, 1, 0);
		repeat (PUW_CYC) @(posedge clk_sys);
		for (int i = 0; i < 5; i++) begin
			rnd = lfsr(rnd);
			do_op({codes[i], 6'h0, rnd[1:0], rnd, 8'hFF} >> (40 - bits[i]), bits[i], 1, 1);
			chk(op_kind_r, kinds[i]);
			if (bits[i] == 32) chk(op_addr_r, {rnd[1:0], rnd});
		end
		do_op(64'h20000000, 32, 0, 0);
		do_op(64'h40000000, 33, 1, 0);
		do_op(64'h0104, 16, 1, 1);
		chk(guard_level_r, 2'h1);
		do_op(64'h20030000, 32, 1, 0);
		do_op(64'h20000000, 32, 1, 1);
		do_op(64'h60, 8, 1, 0);
		do_op(64'h0184, 16, 1, 1);
		@(posedge clk_sys) protect_n <= 1'b0;
		repeat (5) @(posedge clk_sys);
		do_op(64'h0100, 16, 1, 0);
		chk({status_lock_r, guard_level_r}, 3'h5);
		// Status read paused inside its answer byte
		host.pause_at = 4;
		wr(64'h0500, 16);
		host.pause_at = -1;
		chk(rx[7:0], 8'h84);
		chk(host.paused_drive, 1'b0);
		@(posedge clk_sys) protect_n <= 1'b1;
		repeat (5) @(posedge clk_sys);
		do_op(64'h0100, 16, 1, 1);
		wr(64'h9F000000, 32);
		chk(rx[23:0], 24'h5A3C11);
		wr(64'h900000010000, 48);
		chk(rx[15:0], 16'h115A);
		wr(64'hB9, 8);
		chk(sleep_r, 1'b1);
		mark = rejects;
		wr(64'h06, 8);
		chk(write_latch_r, 1'b0);
		chk(rejects - mark, 1);
		wr(64'h0500, 16);
		chk(host.oe_seen, 1'b0);
		wr(64'hAB00000000, 40);
		chk(rx[7:0], 8'h11);
		chk(sleep_r, 1'b0);
		give_verdict();
	end
endmodule // serial_flash_cmd_protect_tb
